// ### common/irq_enable_cfg.svh
// What this block does
// - Enable one passes request, zero blocks it.
// - Enable bits read/write, reset to zero.
// - Word one bit five reads zero, ignores writes.
// - Word zero bits three..zero gate four sources.
// - Word one bits fifteen..eight gate listed sources.
// - Word one bits seven..zero gate listed sources.
// - Word two bits fifteen..eight gate listed sources.
// - Word two bits seven..zero gate listed sources.
`ifndef IRQ_ENABLE_CFG_SVH
`define IRQ_ENABLE_CFG_SVH

// ****************************************
// Register offsets.
// ****************************************
`define IEB_OFS_EN0    4'h0
`define IEB_OFS_EN1    4'h1
`define IEB_OFS_EN2    4'h2
`define IEB_OFS_PEND0  4'h4
`define IEB_OFS_PEND1  4'h5
`define IEB_OFS_PEND2  4'h6
`define IEB_OFS_STATUS 4'h8
`define IEB_OFS_MASK   4'h9

// ****************************************
// Implemented enable bits of each word.
// ****************************************
`define IEB_IMPL_MASK0 16'h000f
`define IEB_IMPL_MASK1 16'hffdf
`define IEB_IMPL_MASK2 16'hffff

// ****************************************
// Reset values and field positions.
// ****************************************
`define IEB_EN_RESET     16'h0000
`define IEB_STATUS_RESET 3'h0
`define IEB_MASK_RESET   3'h0
`define IEB_HOLE_BIT     5

`endif

// ### common/irq_enable_pkg.sv
package irq_enable_pkg;

	typedef logic [15:0] word_t;
	typedef logic [3:0]  addr_t;
	typedef logic [2:0]  lane_t;

endpackage : irq_enable_pkg

// ### rtl/irq_gate_lane.sv
`include "irq_enable_cfg.svh"

module irq_gate_lane #(
	parameter irq_enable_pkg::word_t IMPL_MASK = 16'hffff
) (
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// Register write.
	input  wire logic                  wrEn,
	input  wire irq_enable_pkg::word_t wrData,
	// Request path.
	input  wire irq_enable_pkg::word_t flags,
	output irq_enable_pkg::word_t      enable_reg,
	output irq_enable_pkg::word_t      request_reg,
	output logic                       riseEvent
);

	irq_enable_pkg::word_t request_next;

	// ****************************************
	// Enable storage.
	// ****************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			enable_reg <= `IEB_EN_RESET;
		end else if (wrEn) begin
			enable_reg <= wrData & IMPL_MASK;
		end
	end

	// ****************************************
	// Gating of the requests.
	// ****************************************
	assign request_next = flags & enable_reg;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			request_reg <= '0;
		end else begin
			request_reg <= request_next;
		end
	end

	assign riseEvent = |(request_next & ~request_reg);

endmodule : irq_gate_lane

// ### rtl/interrupt_enable_bank.sv
// Implementation choices: the strobed register port and the placing of the registers.
`include "irq_enable_cfg.svh"

module interrupt_enable_bank (
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// Register port.
	input  wire irq_enable_pkg::addr_t addr,
	input  wire irq_enable_pkg::word_t wrData,
	input  wire logic                  wrStrobe,
	input  wire logic                  rdStrobe,
	output irq_enable_pkg::word_t      rdData,
	// Source flags.
	input  wire irq_enable_pkg::word_t flagWord0,
	input  wire irq_enable_pkg::word_t flagWord1,
	input  wire irq_enable_pkg::word_t flagWord2,
	// Gated requests.
	output irq_enable_pkg::word_t      reqWord0,
	output irq_enable_pkg::word_t      reqWord1,
	output irq_enable_pkg::word_t      reqWord2,
	// Interrupt.
	output logic                       irqOut
);

	// ****************************************
	// Declarations.
	// ****************************************
	localparam irq_enable_pkg::word_t IMPL_MASK [3] = '{
		`IEB_IMPL_MASK0,
		`IEB_IMPL_MASK1,
		`IEB_IMPL_MASK2
	};
	localparam irq_enable_pkg::addr_t EN_OFS [3] = '{
		`IEB_OFS_EN0,
		`IEB_OFS_EN1,
		`IEB_OFS_EN2
	};

	irq_enable_pkg::word_t flagWord  [3];
	irq_enable_pkg::word_t enWord    [3];
	irq_enable_pkg::word_t laneReq   [3];
	irq_enable_pkg::lane_t laneEvent;
	irq_enable_pkg::lane_t laneWrite;
	irq_enable_pkg::word_t rdData_reg;
	irq_enable_pkg::word_t rdData_next;
	irq_enable_pkg::lane_t status_reg;
	irq_enable_pkg::lane_t status_next;
	irq_enable_pkg::lane_t mask_reg;
	logic                  irq_reg;
	logic                  statusRead;

	// ****************************************
	// Address decode.
	// ****************************************
	function automatic logic isHit(
		input irq_enable_pkg::addr_t a,
		input irq_enable_pkg::addr_t ofs
	);
		isHit = (a == ofs);
	endfunction : isHit

	function automatic logic isMapped(
		input irq_enable_pkg::addr_t a
	);
		isMapped = isHit(a, `IEB_OFS_EN0) || isHit(a, `IEB_OFS_EN1) || isHit(a, `IEB_OFS_EN2) ||
			isHit(a, `IEB_OFS_PEND0) || isHit(a, `IEB_OFS_PEND1) || isHit(a, `IEB_OFS_PEND2) ||
			isHit(a, `IEB_OFS_STATUS) || isHit(a, `IEB_OFS_MASK);
	endfunction : isMapped

	assign statusRead = rdStrobe && isHit(addr, `IEB_OFS_STATUS);

	// ****************************************
	// Enable lanes.
	// ****************************************
	assign flagWord[0] = flagWord0;
	assign flagWord[1] = flagWord1;
	assign flagWord[2] = flagWord2;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_lane
			assign laneWrite[i] = wrStrobe && isHit(addr, EN_OFS[i]);

			irq_gate_lane #(
				.IMPL_MASK (IMPL_MASK[i])
			) u_lane (
				.clock       (clock),
				.reset_n     (reset_n),
				.wrEn        (laneWrite[i]),
				.wrData      (wrData),
				.flags       (flagWord[i]),
				.enable_reg  (enWord[i]),
				.request_reg (laneReq[i]),
				.riseEvent   (laneEvent[i])
			);
		end
	endgenerate

	assign reqWord0 = laneReq[0];
	assign reqWord1 = laneReq[1];
	assign reqWord2 = laneReq[2];

	// ****************************************
	// Read data.
	// ****************************************
	always_comb begin
		rdData_next = '0;
		if (rdStrobe) begin
			case (addr)
				`IEB_OFS_EN0:    rdData_next = enWord[0];
				`IEB_OFS_EN1:    rdData_next = enWord[1];
				`IEB_OFS_EN2:    rdData_next = enWord[2];
				`IEB_OFS_PEND0:  rdData_next = laneReq[0];
				`IEB_OFS_PEND1:  rdData_next = laneReq[1];
				`IEB_OFS_PEND2:  rdData_next = laneReq[2];
				`IEB_OFS_STATUS: rdData_next = {13'h0000, status_reg};
				`IEB_OFS_MASK:   rdData_next = {13'h0000, mask_reg};
				default:         rdData_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdData_reg <= '0;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	assign rdData = rdData_reg;

	// ****************************************
	// Event status and mask.
	// ****************************************
	always_comb begin
		status_next = status_reg;
		if (statusRead) begin
			status_next = '0;
		end
		status_next = status_next | laneEvent;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			status_reg <= `IEB_STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mask_reg <= `IEB_MASK_RESET;
		end else if (wrStrobe && isHit(addr, `IEB_OFS_MASK)) begin
			mask_reg <= wrData[2:0];
		end
	end

	// ****************************************
	// Interrupt output.
	// ****************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	assign irqOut = irq_reg;

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	property p_gate(int i);
		##1 laneReq[i] == $past(flagWord[i] & enWord[i]);
	endproperty

	a_gate_word_zero: assert property (p_gate(0))
		else $error("Word zero request does not follow flag and enable.");

	a_gate_word_one: assert property (p_gate(1))
		else $error("Word one request does not follow flag and enable.");

	a_gate_word_two: assert property (p_gate(2))
		else $error("Word two request does not follow flag and enable.");

	a_blocked_when_off: assert property (
		(enWord[1] == 16'h0000 && !laneWrite[1]) |=> (laneReq[1] == 16'h0000)
	) else $error("Request passed while enables were clear.");

	a_reset_clears_en: assert property (
		@(posedge clock) disable iff (1'b0)
		!reset_n |=> (enWord[0] == 16'h0000 && enWord[1] == 16'h0000 && enWord[2] == 16'h0000)
	) else $error("Enables not cleared by reset.");

	a_write_sets_en: assert property (
		laneWrite[2] |=> enWord[2] == $past(wrData)
	) else $error("Write to word two not stored.");

	a_readback_en: assert property (
		(rdStrobe && isHit(addr, `IEB_OFS_EN0)) |=> rdData == $past(enWord[0])
	) else $error("Word zero read-back wrong.");

	a_hole_reads_zero: assert property (
		(rdStrobe && isHit(addr, `IEB_OFS_EN1)) |=> !rdData[`IEB_HOLE_BIT]
	) else $error("Unimplemented bit reads as one.");

	a_hole_no_store: assert property (
		laneWrite[1] |=> !enWord[1][`IEB_HOLE_BIT] && enWord[1] == ($past(wrData) & `IEB_IMPL_MASK1)
	) else $error("Unimplemented bit was stored.");

	a_word0_low_only: assert property (
		laneWrite[0] |=> enWord[0] == ($past(wrData) & `IEB_IMPL_MASK0)
	) else $error("Word zero stored an unimplemented bit.");

	a_read_one_cycle: assert property (
		!rdStrobe |=> rdData == 16'h0000
	) else $error("Read data outside its cycle.");

	a_event_sets_status: assert property (
		laneEvent[0] |=> status_reg[0] ##1
			((irqOut == $past(mask_reg[0])) || ($past(status_reg[2:1] & mask_reg[2:1]) != 2'h0))
	) else $error("Event did not set status.");

	a_irq_level: assert property (
		##1 irqOut == $past(|(status_reg & mask_reg))
	) else $error("Interrupt output does not follow masked status.");

	a_unmapped_read_zero: assert property (
		(rdStrobe && !isMapped(addr)) |=> rdData == 16'h0000
	) else $error("Unmapped address read as nonzero.");

	a_status_read_clear: assert property (
		(statusRead && laneEvent == 3'h0) |=> status_reg == 3'h0
	) else $error("Status read did not clear the status.");

	a_status_event_wins: assert property (
		(laneEvent != 3'h0) |=> (status_reg & $past(laneEvent)) == $past(laneEvent)
	) else $error("Event did not set its status bit.");

	a_status_sticky: assert property (
		!statusRead |=> (status_reg & $past(status_reg)) == $past(status_reg)
	) else $error("Status bit dropped without a read.");

	a_status_only_event: assert property (
		##1 (status_reg & ~$past(status_reg) & ~$past(laneEvent)) == 3'h0
	) else $error("Status bit set without an event.");

	a_mask_stored: assert property (
		(wrStrobe && isHit(addr, `IEB_OFS_MASK)) |=> mask_reg == $past(wrData[2:0])
	) else $error("Mask write not stored.");

	a_pend_readback: assert property (
		(rdStrobe && isHit(addr, `IEB_OFS_PEND0)) |=> rdData == $past(laneReq[0])
	) else $error("Pending word read-back wrong.");

	a_status_readback: assert property (
		(rdStrobe && isHit(addr, `IEB_OFS_STATUS)) |=> rdData == {13'h0000, $past(status_reg)}
	) else $error("Status read-back wrong.");

	a_unimpl_bits_clear: assert property (
		(enWord[0] & ~`IEB_IMPL_MASK0) == 16'h0000 && (enWord[1] & ~`IEB_IMPL_MASK1) == 16'h0000
	) else $error("Unimplemented enable bit holds a one.");

	a_reset_quiet: assert property (
		@(posedge clock) disable iff (1'b0)
		!reset_n |=> (irqOut == 1'b0 && status_reg == 3'h0 && mask_reg == 3'h0 && rdData == 16'h0000)
	) else $error("Status, mask or outputs not cleared by reset.");

	property p_hold(int i);
		!laneWrite[i] |=> enWord[i] == $past(enWord[i]);
	endproperty

	a_hold_word_zero: assert property (p_hold(0))
		else $error("Word zero enables changed without a write.");

	a_hold_word_one: assert property (p_hold(1))
		else $error("Word one enables changed without a write.");

	a_hold_word_two: assert property (p_hold(2))
		else $error("Word two enables changed without a write.");

	// ****************************************
	// Cover properties.
	// ****************************************
	c_enable_then_request: cover property (
		laneWrite[0] && wrData[3] ##1 flagWord[0][3] ##1 laneReq[0][3]
	);

	c_irq_raised: cover property (
		!irqOut ##1 irqOut
	);

	c_status_cleared: cover property (
		statusRead && status_reg != 3'h0 ##1 status_reg == 3'h0
	);

	c_hole_written: cover property (
		laneWrite[1] && wrData[`IEB_HOLE_BIT]
	);

	c_pend_read: cover property (
		rdStrobe && isHit(addr, `IEB_OFS_PEND0) && laneReq[0] != 16'h0000
	);

endmodule : interrupt_enable_bank

// ### bench/irq_source_model.sv
module irq_source_model (
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// Flag load.
	input  wire logic                  load,
	input  wire irq_enable_pkg::word_t value0,
	input  wire irq_enable_pkg::word_t value1,
	input  wire irq_enable_pkg::word_t value2,
	// Source flags.
	output irq_enable_pkg::word_t      flagWord0,
	output irq_enable_pkg::word_t      flagWord1,
	output irq_enable_pkg::word_t      flagWord2
);
	timeunit 1ns;
	timeprecision 1ps;

	// Sources stand as already routed to their pins, so each flag reaches the block.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			flagWord0 <= 16'h0000;
			flagWord1 <= 16'h0000;
			flagWord2 <= 16'h0000;
		end else if (load) begin
			flagWord0 <= value0;
			flagWord1 <= value1;
			flagWord2 <= value2;
		end
	end
endmodule : irq_source_model

// ### bench/tb.sv
`include "irq_enable_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  clock;
	logic                  reset_n;
	logic                  wrStrobe;
	logic                  rdStrobe;
	logic                  load;
	logic                  irqOut;
	irq_enable_pkg::addr_t addr;
	irq_enable_pkg::word_t wrData, rdData, v0, v1, v2, f0, f1, f2, r0, r1, r2, rv;
	irq_enable_pkg::word_t impl [3];
	irq_enable_pkg::word_t req [3];
	int                    error_cnt;
	int                    compares;

	always_comb req = '{r0, r1, r2};

	irq_source_model src (.clock(clock), .reset_n(reset_n), .load(load), .value0(v0), .value1(v1),
		.value2(v2), .flagWord0(f0), .flagWord1(f1), .flagWord2(f2));

	interrupt_enable_bank dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .flagWord0(f0), .flagWord1(f1),
		.flagWord2(f2), .reqWord0(r0), .reqWord1(r1), .reqWord2(r2), .irqOut(irqOut));

	// ****************************************
	// Bus and compare tasks.
	// ****************************************
	task chk(input string nm, input irq_enable_pkg::word_t exp, input irq_enable_pkg::word_t got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task chkBit(input string nm, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", nm, exp, got);
		end
	endtask : chkBit

	task wr(input irq_enable_pkg::addr_t a, input irq_enable_pkg::word_t d);
		@(posedge clock);
		wrStrobe <= 1'b1;
		addr     <= a;
		wrData   <= d;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask : wr

	task rd(input irq_enable_pkg::addr_t a, output irq_enable_pkg::word_t d);
		@(posedge clock);
		rdStrobe <= 1'b1;
		addr     <= a;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1 d = rdData;
	endtask : rd

	task setFlags(input irq_enable_pkg::word_t a, input irq_enable_pkg::word_t b, input irq_enable_pkg::word_t c);
		@(posedge clock);
		load <= 1'b1;
		v0   <= a;
		v1   <= b;
		v2   <= c;
		@(posedge clock);
		load <= 1'b0;
	endtask : setFlags

	task step;
		@(posedge clock);
		#1;
	endtask : step

	task conclude;
		if (error_cnt == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		#100us;
		error_cnt++;
		conclude();
	end

	// ****************************************
	// Test sequence.
	// ****************************************
	initial begin
		{reset_n, wrStrobe, rdStrobe, load, addr, wrData, v0, v1, v2} = '0;
		error_cnt = 0;
		compares  = 0;
		impl      = '{`IEB_IMPL_MASK0, `IEB_IMPL_MASK1, `IEB_IMPL_MASK2};
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		for (int w = 0; w < 3; w++) begin
			rd(4'(w), rv);
			chk("enable reset", 16'h0000, rv);
		end
		for (int w = 0; w < 3; w++) begin
			wr(4'(w), 16'hffff);
		end
		for (int w = 0; w < 3; w++) begin
			rd(4'(w), rv);
			chk("enable readback", impl[w], rv);
		end
		setFlags(16'hffff, 16'hffff, 16'hffff);
		for (int w = 0; w < 3; w++) begin
			for (int i = 0; i < 16; i++) begin
				wr(4'(w), 16'h0001 << i);
				step();
				chk("gated request", (16'h0001 << i) & impl[w], req[w]);
			end
			wr(4'(w), impl[w]);
		end
		setFlags(16'h0005, 16'h0000, 16'h0000);
		step();
		chk("flag gating", 16'h0005, r0);
		chk("flag gating", 16'h0000, r1);
		rd(`IEB_OFS_PEND0, rv);
		chk("pending word", 16'h0005, rv);
		wr(`IEB_OFS_EN0, 16'h0004);
		step();
		chk("enable cleared", 16'h0004, r0);
		wr(4'h3, 16'hffff);
		rd(4'h3, rv);
		chk("unmapped read", 16'h0000, rv);
		rd(`IEB_OFS_EN0, rv);
		chk("unmapped write", 16'h0004, rv);
		rd(`IEB_OFS_STATUS, rv);
		wr(`IEB_OFS_MASK, 16'h0001);
		setFlags(16'h0000, 16'h0000, 16'h0000);
		wr(`IEB_OFS_EN0, 16'h000f);
		setFlags(16'h0001, 16'h0000, 16'h0000);
		step();
		step();
		chkBit("irq raised", 1'b1, irqOut);
		rd(`IEB_OFS_STATUS, rv);
		chk("status", 16'h0001, rv);
		step();
		chkBit("irq cleared", 1'b0, irqOut);
		wr(`IEB_OFS_MASK, 16'h0000);
		setFlags(16'h0003, 16'h0000, 16'h0000);
		step();
		step();
		chkBit("irq masked", 1'b0, irqOut);
		rd(`IEB_OFS_STATUS, rv);
		chk("masked status", 16'h0001, rv);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		for (int w = 0; w < 3; w++) begin
			rd(4'(w), rv);
			chk("enable after reset", 16'h0000, rv);
		end
		chk("request after reset", 16'h0000, r0);
		chkBit("irq after reset", 1'b0, irqOut);
		conclude();
	end
endmodule : tb
